// ---- irq_enable_priority_extint.sv ----
// interrupt enables, group priority selection and external channel flags
`timescale 1ns/10ps
module irq_enable_priority_extint
	import irq_ctrl_pkg::*;
#(
	parameter int EXT_CHANNELS = NUM_EXT
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	// register port
	input  wire logic [7:0]  addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output      logic [7:0]  rdata_o,
	// interrupt sources
	input  wire logic [7:0]  ext_pin_i,
	input  wire logic [31:0] src_req_i,
	// core side
	input  wire logic        ack_i,
	input  wire logic [4:0]  ack_id_i,
	output      logic [31:0] gated_req_o,
	output      logic        irq_valid_o,
	output      logic [4:0]  irq_id_o,
	output      logic [1:0]  irq_level_o
);

	if (EXT_CHANNELS != NUM_EXT) begin : g_check
		$error("irq_enable_priority_extint serves exactly eight external channels");
	end

	typedef struct packed {
		logic [7:0] pin_meta;
		logic [7:0] pin_sync;
		logic [7:0] pin_prev;
		logic [7:0] ext_channel_enables;
		logic [7:0] ext_pending_flags;
		logic [7:0] ext_sense_type;
		logic [7:0] ext_trigger_polarity;
		logic [7:0] ext_dual_edge_select;
		logic [7:0] global_and_pin_irq_enables;
		logic [7:0] serial_irq_enables;
		logic [7:0] timer_irq_enables;
		logic [7:0] misc_peripheral_irq_enables;
		logic [7:0] extra_serial_irq_enables;
		logic [7:0] upper_ext_irq_enables;
		logic [7:0] group_priority_low_bits;
		logic [7:0] group_priority_high_bits;
		logic [7:0] rdata;
		logic       irq_valid;
		logic [4:0] irq_id;
		logic [1:0] irq_level;
	} state_s;

	state_s q;
	state_s next_q;

	logic [7:0]  trig;
	logic [7:0]  ack_clr;
	logic [31:0] enable_vec;
	logic [31:0] raw_req;
	logic [31:0] gated;
	logic        global_irq_gate;
	logic        wr_flags;

	// level of the group that a source belongs to
	function automatic logic [1:0] src_level(input logic [4:0] id,
	                                         input logic [7:0] lo,
	                                         input logic [7:0] hi);
		logic [2:0] g;
		g = id[4:2];
		return {hi[g], lo[g]};
	endfunction : src_level

	// highest level wins; scanning downward with >= lets the lower number win a tie
	function automatic logic [7:0] pick(input logic [31:0] req,
	                                    input logic [7:0]  lo,
	                                    input logic [7:0]  hi);
		logic       found;
		logic [1:0] best;
		logic [4:0] id;
		logic [4:0] n;
		found = 1'b0;
		best  = 2'b00;
		id    = 5'h00;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			n = i[4:0];
			if (req[i] && (!found || src_level(n, lo, hi) >= best)) begin
				found = 1'b1;
				best  = src_level(n, lo, hi);
				id    = n;
			end
		end
		return {found, best, id};
	endfunction : pick

	// trigger detection per channel
	always_comb begin
		for (int c = 0; c < NUM_EXT; c++) begin
			logic s;
			logic p;
			logic rise;
			logic fall;
			s    = q.pin_sync[c];
			p    = q.pin_prev[c];
			rise = s & ~p;
			fall = ~s & p;
			if (q.ext_dual_edge_select[c]) begin
				trig[c] = rise | fall;
			end else if (q.ext_sense_type[c]) begin
				trig[c] = q.ext_trigger_polarity[c] ? fall : rise;
			end else begin
				trig[c] = q.ext_trigger_polarity[c] ? ~s : s;
			end
			trig[c] = trig[c] & q.ext_channel_enables[c];
			ack_clr[c] = ack_i && (ack_id_i == ext_src(c));
		end
	end

	// source request and enable vectors
	always_comb begin
		enable_vec = {q.upper_ext_irq_enables[1:0],
		              q.extra_serial_irq_enables[5:0],
		              q.misc_peripheral_irq_enables[5:0],
		              q.timer_irq_enables[5:0],
		              q.serial_irq_enables[5:0],
		              q.global_and_pin_irq_enables[5:0]};
		raw_req = src_req_i;
		for (int c = 0; c < NUM_EXT; c++) begin
			raw_req[ext_src(c)] = q.ext_pending_flags[c] & q.ext_channel_enables[c];
		end
		global_irq_gate = q.global_and_pin_irq_enables[GATE_BIT];
		gated = global_irq_gate ? (raw_req & enable_vec) : 32'h0000_0000;
	end

	assign wr_flags = wr_i && (addr_i == ADDR_EXT_FLAG);

	always_comb begin
		logic [7:0] keep;
		keep   = wr_flags ? wdata_i : ALL_ONES;
		next_q = q;

		// second stage only reads the first; nothing else looks at pin_meta
		next_q.pin_meta = ext_pin_i;
		next_q.pin_sync = q.pin_meta;
		next_q.pin_prev = q.pin_sync;

		// a trigger in the clearing cycle survives the clear
		next_q.ext_pending_flags = (q.ext_pending_flags & keep & ~ack_clr) | trig;

		if (wr_i) begin
			case (addr_i)
				ADDR_EXT_ENAB:  next_q.ext_channel_enables = wdata_i;
				ADDR_EXT_SENSE: next_q.ext_sense_type = wdata_i;
				ADDR_EXT_POL:   next_q.ext_trigger_polarity = wdata_i;
				ADDR_EXT_BOTH:  next_q.ext_dual_edge_select = wdata_i;
				ADDR_IE0:       next_q.global_and_pin_irq_enables = wdata_i & IE0_MASK;
				ADDR_IE1:       next_q.serial_irq_enables = wdata_i & IEX_MASK;
				ADDR_IE2:       next_q.timer_irq_enables = wdata_i & IEX_MASK;
				ADDR_IE3:       next_q.misc_peripheral_irq_enables = wdata_i & IEX_MASK;
				ADDR_IE4:       next_q.extra_serial_irq_enables = wdata_i & IEX_MASK;
				ADDR_IE5:       next_q.upper_ext_irq_enables = wdata_i & IEX_MASK;
				ADDR_PRIO_LO:   next_q.group_priority_low_bits = wdata_i;
				ADDR_PRIO_HI:   next_q.group_priority_high_bits = wdata_i;
				default: ;
			endcase
		end

		next_q.rdata = 8'h00;
		if (rd_i) begin
			case (addr_i)
				ADDR_EXT_ENAB:  next_q.rdata = q.ext_channel_enables;
				ADDR_EXT_FLAG:  next_q.rdata = q.ext_pending_flags;
				ADDR_EXT_SENSE: next_q.rdata = q.ext_sense_type;
				ADDR_EXT_POL:   next_q.rdata = q.ext_trigger_polarity;
				ADDR_EXT_BOTH:  next_q.rdata = q.ext_dual_edge_select;
				ADDR_IE0:       next_q.rdata = q.global_and_pin_irq_enables;
				ADDR_IE1:       next_q.rdata = q.serial_irq_enables;
				ADDR_IE2:       next_q.rdata = q.timer_irq_enables;
				ADDR_IE3:       next_q.rdata = q.misc_peripheral_irq_enables;
				ADDR_IE4:       next_q.rdata = q.extra_serial_irq_enables;
				ADDR_IE5:       next_q.rdata = q.upper_ext_irq_enables;
				ADDR_PRIO_LO:   next_q.rdata = q.group_priority_low_bits;
				ADDR_PRIO_HI:   next_q.rdata = q.group_priority_high_bits;
				default:        next_q.rdata = 8'h00;
			endcase
		end

		// the selection is registered so the core sees a stable winner
		{next_q.irq_valid, next_q.irq_level, next_q.irq_id} =
			pick(gated, q.group_priority_low_bits, q.group_priority_high_bits);
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign rdata_o     = q.rdata;
	assign gated_req_o = gated;
	assign irq_valid_o = q.irq_valid;
	assign irq_id_o    = q.irq_id;
	assign irq_level_o = q.irq_level;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	a_flag_set_trigger: assert property (trig[0] |=> q.ext_pending_flags[0])
		else $error("trigger on channel 0 did not set its flag");
	a_ack_clears_flag: assert property (
		(ack_i && ack_id_i == ext_src(5) && !trig[5] && q.ext_pending_flags[5])
		|=> !q.ext_pending_flags[5])
		else $error("service entry did not clear channel 5 flag");
	a_write_zero_clears: assert property (
		(wr_flags && trig == 8'h00 && !ack_i) |=> q.ext_pending_flags ==
		($past(q.ext_pending_flags) & $past(wdata_i)))
		else $error("flag write did not clear exactly the zero bits");
	a_write_one_inert: assert property (
		(wr_flags && trig == 8'h00) |=> (q.ext_pending_flags & ~$past(q.ext_pending_flags)) == 8'h00)
		else $error("flag write created a request");
	a_level_high_sets: assert property (
		(!q.ext_sense_type[1] && !q.ext_dual_edge_select[1] && !q.ext_trigger_polarity[1]
		 && q.ext_channel_enables[1] && q.pin_sync[1]) |=> q.ext_pending_flags[1])
		else $error("high level did not set channel 1 flag");
	a_both_edge_fall: assert property (
		(q.ext_dual_edge_select[2] && q.ext_channel_enables[2] && !wr_i
		 && !q.pin_sync[2] && q.pin_prev[2]) |=> q.ext_pending_flags[2])
		else $error("falling edge ignored in dual-edge mode");
	a_sync_edge_delay: assert property (
		(q.ext_sense_type[3] && !q.ext_dual_edge_select[3] && !q.ext_trigger_polarity[3]
		 && q.ext_channel_enables[3] && !q.ext_pending_flags[3] && !wr_i && !ack_i
		 && !ext_pin_i[3] ##1 ext_pin_i[3] && !wr_i && !ack_i)
		|=> !q.ext_pending_flags[3] ##2 q.ext_pending_flags[3])
		else $error("rising edge not flagged three cycles after the pin");
	a_gate_blocks_all: assert property (!global_irq_gate |-> gated_req_o == 32'h0000_0000)
		else $error("request passed a closed global gate");
	a_winner_level: assert property (
		irq_valid_o |-> irq_level_o ==
		src_level(irq_id_o, $past(q.group_priority_low_bits), $past(q.group_priority_high_bits)))
		else $error("reported level differs from the group level");
	a_tie_lower_wins: assert property (
		(gated[0] && gated[3] && q.group_priority_high_bits[0] && q.group_priority_low_bits[0])
		|=> irq_id_o == 5'h00)
		else $error("tie within a group not won by the lower number");
	a_readback_sense: assert property ((rd_i && addr_i == ADDR_EXT_SENSE && !wr_i)
		|=> rdata_o == $past(q.ext_sense_type))
		else $error("sense register read back wrong");

	// register port: read data stands for one cycle only, zero otherwise
	a_rdata_idle_zero: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data not zero outside a read");
	a_read_enables: assert property ((rd_i && addr_i == ADDR_EXT_ENAB)
		|=> rdata_o == $past(q.ext_channel_enables))
		else $error("channel enable register read back wrong");
	a_read_flags: assert property ((rd_i && addr_i == ADDR_EXT_FLAG)
		|=> rdata_o == $past(q.ext_pending_flags))
		else $error("pending flag register read back wrong");
	a_read_polarity: assert property ((rd_i && addr_i == ADDR_EXT_POL)
		|=> rdata_o == $past(q.ext_trigger_polarity))
		else $error("polarity register read back wrong");
	a_read_dual_edge: assert property ((rd_i && addr_i == ADDR_EXT_BOTH)
		|=> rdata_o == $past(q.ext_dual_edge_select))
		else $error("dual-edge register read back wrong");
	a_read_gate_reg: assert property ((rd_i && addr_i == ADDR_IE0)
		|=> rdata_o == $past(q.global_and_pin_irq_enables))
		else $error("global enable register read back wrong");
	a_read_serial: assert property ((rd_i && addr_i == ADDR_IE1)
		|=> rdata_o == $past(q.serial_irq_enables))
		else $error("serial enable register read back wrong");
	a_read_timer: assert property ((rd_i && addr_i == ADDR_IE2)
		|=> rdata_o == $past(q.timer_irq_enables))
		else $error("timer enable register read back wrong");
	a_read_misc: assert property ((rd_i && addr_i == ADDR_IE3)
		|=> rdata_o == $past(q.misc_peripheral_irq_enables))
		else $error("misc enable register read back wrong");
	a_read_extra: assert property ((rd_i && addr_i == ADDR_IE4)
		|=> rdata_o == $past(q.extra_serial_irq_enables))
		else $error("extra serial enable register read back wrong");
	a_read_upper: assert property ((rd_i && addr_i == ADDR_IE5)
		|=> rdata_o == $past(q.upper_ext_irq_enables))
		else $error("upper external enable register read back wrong");
	a_read_prio_lo: assert property ((rd_i && addr_i == ADDR_PRIO_LO)
		|=> rdata_o == $past(q.group_priority_low_bits))
		else $error("low priority register read back wrong");
	a_read_prio_hi: assert property ((rd_i && addr_i == ADDR_PRIO_HI)
		|=> rdata_o == $past(q.group_priority_high_bits))
		else $error("high priority register read back wrong");

	// writes land at the strobe edge; masked-off enable bits never store
	a_write_sense: assert property ((wr_i && addr_i == ADDR_EXT_SENSE)
		|=> q.ext_sense_type == $past(wdata_i))
		else $error("sense register write lost");
	a_write_polarity: assert property ((wr_i && addr_i == ADDR_EXT_POL)
		|=> q.ext_trigger_polarity == $past(wdata_i))
		else $error("polarity register write lost");
	a_write_dual_edge: assert property ((wr_i && addr_i == ADDR_EXT_BOTH)
		|=> q.ext_dual_edge_select == $past(wdata_i))
		else $error("dual-edge register write lost");
	a_write_enables: assert property ((wr_i && addr_i == ADDR_EXT_ENAB)
		|=> q.ext_channel_enables == $past(wdata_i))
		else $error("channel enable register write lost");
	a_write_gate_reg: assert property ((wr_i && addr_i == ADDR_IE0)
		|=> q.global_and_pin_irq_enables == ($past(wdata_i) & IE0_MASK))
		else $error("global enable register write wrong");
	a_write_prio_lo: assert property ((wr_i && addr_i == ADDR_PRIO_LO)
		|=> q.group_priority_low_bits == $past(wdata_i))
		else $error("low priority register write lost");
	a_write_prio_hi: assert property ((wr_i && addr_i == ADDR_PRIO_HI)
		|=> q.group_priority_high_bits == $past(wdata_i))
		else $error("high priority register write lost");
	a_unused_bit_six: assert property (q.global_and_pin_irq_enables[6] == 1'b0)
		else $error("unused global enable bit stored a one");
	a_top_bits_zero: assert property (((q.serial_irq_enables | q.timer_irq_enables
		| q.misc_peripheral_irq_enables | q.extra_serial_irq_enables
		| q.upper_ext_irq_enables) & ~IEX_MASK) == 8'h00)
		else $error("read-only enable bits stored a one");

	// trigger decode per mode
	a_level_low_sets: assert property (
		(!q.ext_sense_type[1] && !q.ext_dual_edge_select[1] && q.ext_trigger_polarity[1]
		 && q.ext_channel_enables[1] && !q.pin_sync[1]) |=> q.ext_pending_flags[1])
		else $error("low level did not set channel 1 flag");
	a_rise_sets: assert property (
		(q.ext_sense_type[0] && !q.ext_dual_edge_select[0] && !q.ext_trigger_polarity[0]
		 && q.ext_channel_enables[0] && q.pin_sync[0] && !q.pin_prev[0]) |=> q.ext_pending_flags[0])
		else $error("rising edge did not set channel 0 flag");
	a_fall_sets: assert property (
		(q.ext_sense_type[0] && !q.ext_dual_edge_select[0] && q.ext_trigger_polarity[0]
		 && q.ext_channel_enables[0] && !q.pin_sync[0] && q.pin_prev[0]) |=> q.ext_pending_flags[0])
		else $error("falling edge did not set channel 0 flag");
	a_edge_ignores_level: assert property (
		(q.ext_sense_type[0] && !q.ext_dual_edge_select[0] && q.pin_sync[0] == q.pin_prev[0])
		|-> !trig[0])
		else $error("edge-sensed channel 0 triggered on a steady pin");
	a_dual_ignores_level: assert property (
		(q.ext_dual_edge_select[0] && q.pin_sync[0] == q.pin_prev[0]) |-> !trig[0])
		else $error("dual-edge channel 0 triggered on a steady pin");
	a_disabled_no_trig: assert property ((trig & ~q.ext_channel_enables) == 8'h00)
		else $error("disabled channel triggered");
	a_disabled_stays_clear: assert property (
		(!q.ext_channel_enables[0] && !q.ext_pending_flags[0]) |=> !q.ext_pending_flags[0])
		else $error("disabled channel 0 flag set");
	a_ack_clears_ch4: assert property (
		(ack_i && ack_id_i == ext_src(4) && !trig[4]) |=> !q.ext_pending_flags[4])
		else $error("service entry did not clear channel 4 flag");

	// request gating per source group
	a_port0_source: assert property (
		(global_irq_gate && q.global_and_pin_irq_enables[4] && src_req_i[4]) |-> gated_req_o[4])
		else $error("port 0 pin-change request not passed");
	a_port7_source: assert property (
		(global_irq_gate && q.global_and_pin_irq_enables[5] && src_req_i[5]) |-> gated_req_o[5])
		else $error("port 7 pin-change request not passed");
	a_serial_source: assert property (
		(global_irq_gate && q.serial_irq_enables[0] && src_req_i[6]) |-> gated_req_o[6])
		else $error("serial 0 receive request not passed");
	a_timer_source: assert property (
		(global_irq_gate && q.timer_irq_enables[5] && src_req_i[17]) |-> gated_req_o[17])
		else $error("timer 5 request not passed");
	a_adc_source: assert property (
		(global_irq_gate && q.misc_peripheral_irq_enables[0] && src_req_i[18]) |-> gated_req_o[18])
		else $error("converter request not passed");
	a_uart2_source: assert property (
		(global_irq_gate && q.extra_serial_irq_enables[0] && src_req_i[24]) |-> gated_req_o[24])
		else $error("serial 2 receive request not passed");
	a_ext7_source: assert property (
		(global_irq_gate && q.upper_ext_irq_enables[1] && q.ext_pending_flags[7]
		 && q.ext_channel_enables[7]) |-> gated_req_o[31])
		else $error("external channel 7 request not passed");
	a_ext_ignores_src: assert property (!q.ext_pending_flags[0] |-> !gated_req_o[0])
		else $error("peripheral input leaked onto an external source");
	a_valid_follows: assert property (irq_valid_o == $past(|gated_req_o))
		else $error("request valid does not follow the gated requests");

	c_edge_flag: cover property (q.ext_sense_type[0] && trig[0]);
	c_ack_clear: cover property (ack_i && |ack_clr);
	c_high_level_win: cover property (irq_valid_o && irq_level_o == 2'h3);
	c_set_beats_clear: cover property (wr_flags && |(trig & ~wdata_i));
	c_dual_edge: cover property (q.ext_dual_edge_select[0] && trig[0]);

endmodule : irq_enable_priority_extint

// ---- irq_ctrl_pkg.sv ----
// constants for the interrupt enable, priority and external channel block
// Behaviour
// - trigger condition sets the channel pending flag
// - service entry clears that channel's pending flag
// - writing zero clears a pending flag
// - sense bit: zero level, one edge
// - polarity picks level or edge direction
// - polarity zero high/rising, one low/falling
// - dual-edge bit triggers on both edges
// - dual-edge set ignores sense and polarity
// - channel enable bit enables pin interrupt
// - global gate bit seven blocks all requests
// - first register: pin-change and external 3..0
// - second register: serial, bus, spi enables
// - third register: timer 5..0 enables
// - fourth register: misc peripheral enables
// - fifth register: ext 5,4 and serial enables
// - sixth register: ext 7,6, bits 5..2 stored but unused, 7..6 read-only
// - group level from high and low bits
// - 32 sources in 8 groups of 4
// - equal level: lower source number wins
package irq_ctrl_pkg;

	localparam int         NUM_SRC      = 32;
	localparam int         NUM_GROUP    = 8;
	localparam int         GROUP_SIZE   = 4;
	localparam int         NUM_EXT      = 8;
	localparam int         EXT_LOW_CNT  = 4;
	localparam int         EXT_HIGH_BASE = 28;
	localparam int         GATE_BIT     = 7;

	localparam logic [7:0] ADDR_EXT_ENAB  = 8'hA3;
	localparam logic [7:0] ADDR_EXT_FLAG  = 8'hA4;
	localparam logic [7:0] ADDR_EXT_SENSE = 8'hA5;
	localparam logic [7:0] ADDR_EXT_POL   = 8'hA6;
	localparam logic [7:0] ADDR_EXT_BOTH  = 8'hA7;
	localparam logic [7:0] ADDR_IE0       = 8'hA8;
	localparam logic [7:0] ADDR_IE1       = 8'hA9;
	localparam logic [7:0] ADDR_IE2       = 8'hAA;
	localparam logic [7:0] ADDR_IE3       = 8'hAB;
	localparam logic [7:0] ADDR_IE4       = 8'hAC;
	localparam logic [7:0] ADDR_IE5       = 8'hAD;
	localparam logic [7:0] ADDR_PRIO_LO   = 8'hB8;
	localparam logic [7:0] ADDR_PRIO_HI   = 8'hF8;

	// writable bits of each enable register, the rest read as zero
	localparam logic [7:0] IE0_MASK    = 8'hBF;
	localparam logic [7:0] IEX_MASK    = 8'h3F;
	localparam logic [7:0] REG_RESET   = 8'h00;
	localparam logic [7:0] ALL_ONES    = 8'hFF;

	// source number served by an external channel
	function automatic logic [4:0] ext_src(input int ch);
		int s;
		s = (ch < EXT_LOW_CNT) ? ch : ch - EXT_LOW_CNT + EXT_HIGH_BASE;
		return s[4:0];
	endfunction : ext_src

endpackage : irq_ctrl_pkg

// ---- core_svc_model.sv ----
// behavioural core that acknowledges the winning request
`timescale 1ns/10ps
module core_svc_model (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	// control from bench
	input  wire logic       svc_en_i,
	input  wire logic [3:0] delay_i,
	// request side
	input  wire logic       irq_valid_i,
	input  wire logic [4:0] irq_id_i,
	output      logic       ack_o,
	output      logic [4:0] ack_id_o
);
	logic [3:0] wt;
	logic [1:0] hold;

	// three-cycle hold-off covers the two cycles the registered request needs to drop
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ack_o    <= 1'h0;
			ack_id_o <= 5'h00;
			wt       <= 4'h0;
			hold     <= 2'h0;
		end else begin
			ack_o    <= 1'h0;
			ack_id_o <= ~ack_id_o;
			if (hold != 2'h0) begin
				hold <= hold - 2'h1;
			end else if (svc_en_i && irq_valid_i) begin
				if (wt == delay_i) begin
					ack_o    <= 1'h1;
					ack_id_o <= irq_id_i;
					wt       <= 4'h0;
					hold     <= 2'h3;
				end else begin
					wt <= wt + 4'h1;
				end
			end
		end
	end
endmodule : core_svc_model

// ---- irq_enable_priority_extint_tb.sv ----
// self-checking bench for the interrupt enable and priority block
`timescale 1ns/10ps
module irq_enable_priority_extint_tb import irq_ctrl_pkg::*; ;
	logic        clk, nrst, wr, rd, ack, svc_en, valid;
	logic [7:0]  addr, wdata, rdata, pin;
	logic [31:0] src, gated;
	logic [4:0]  ack_id, irq_id, last_id;
	logic [1:0]  lvl;
	logic [3:0]  dly;
	int          n_mismatch = 0;
	int          checks_done = 0;

	irq_enable_priority_extint u_dut (.clk_i(clk), .nrst_i(nrst), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .ext_pin_i(pin),
		.src_req_i(src), .ack_i(ack), .ack_id_i(ack_id), .gated_req_o(gated),
		.irq_valid_o(valid), .irq_id_o(irq_id), .irq_level_o(lvl));
	core_svc_model u_core (.clk_i(clk), .nrst_i(nrst), .svc_en_i(svc_en), .delay_i(dly),
		.irq_valid_i(valid), .irq_id_i(irq_id), .ack_o(ack), .ack_id_o(ack_id));

	always @(posedge clk) if (ack === 1'h1) last_id <= ack_id;

	task automatic end_of_test();
		if (n_mismatch == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask : wr_reg

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd   <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1 chk(32'(rdata), 32'(exp));
	endtask : rd_chk

	task automatic t_regs();
		logic [7:0] a [13] = '{8'hA3, 8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'hA8, 8'hA9, 8'hAA,
			8'hAB, 8'hAC, 8'hAD, 8'hB8, 8'hF8};
		logic [7:0] m [13] = '{8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hBF, 8'h3F, 8'h3F,
			8'h3F, 8'h3F, 8'h3F, 8'hFF, 8'hFF};
		for (int i = 0; i < 13; i++) rd_chk(a[i], 8'h00);
		for (int i = 0; i < 13; i++) begin
			wr_reg(a[i], 8'hFF);
			rd_chk(a[i], m[i]);
		end
		rd_chk(8'h00, 8'h00);
		// enables go first so that no flag sets while the rest clears
		for (int i = 0; i < 13; i++) wr_reg(a[i], 8'h00);
	endtask : t_regs

	// cfg holds both, polarity and sense for channel 0
	task automatic t_trig(input logic [2:0] cfg, input logic fr, to, en, exp);
		wr_reg(8'hA3, {7'h00, en});
		wr_reg(8'hA5, {7'h00, cfg[0]});
		wr_reg(8'hA6, {7'h00, cfg[1]});
		wr_reg(8'hA7, {7'h00, cfg[2]});
		@(posedge clk);
		pin[0] <= fr;
		repeat (5) @(posedge clk);
		wr_reg(8'hA4, 8'h00);
		@(posedge clk);
		pin[0] <= to;
		repeat (5) @(posedge clk);
		rd_chk(8'hA4, {7'h00, exp});
	endtask : t_trig

	task automatic t_serve();
		wr_reg(8'hA3, 8'h10);
		wr_reg(8'hA5, 8'h10);
		wr_reg(8'hA7, 8'h00);
		wr_reg(8'hF8, 8'h80);
		wr_reg(8'hAC, 8'h10);
		wr_reg(8'hA8, 8'h80);
		@(posedge clk);
		pin <= 8'h10;
		repeat (5) @(posedge clk);
		#1 chk(32'(valid), 32'h1);
		chk(32'(irq_id), 32'h1C);
		chk(32'(lvl), 32'h2);
		chk(gated, 32'h1000_0000);
		wr_reg(8'hA8, 8'h00);
		repeat (2) @(posedge clk);
		#1 chk(gated, 32'h0);
		chk(32'(valid), 32'h0);
		wr_reg(8'hA8, 8'h80);
		svc_en <= 1'h1;
		repeat (12) @(posedge clk);
		chk(32'(last_id), 32'h1C);
		rd_chk(8'hA4, 8'h00);
		@(posedge clk);
		svc_en <= 1'h0;
		pin    <= 8'h00;
		wr_reg(8'hA3, 8'h00);
		wr_reg(8'hF8, 8'h00);
	endtask : t_serve

	task automatic t_prio();
		src <= 32'h0FFF_FFF0;
		for (int k = 0; k < 4; k++) begin
			wr_reg(8'hA9 + 8'(k), 8'h01);
			#1 chk(gated, 32'h1 << (6 + 6 * k));
			wr_reg(8'hA9 + 8'(k), 8'h00);
		end
		src <= 32'h0000_1020;
		wr_reg(8'hA8, 8'hA0);
		wr_reg(8'hAA, 8'h01);
		repeat (2) @(posedge clk);
		#1 chk(gated, 32'h0000_1020);
		chk(32'(irq_id), 32'h05);
		wr_reg(8'hF8, 8'h08);
		repeat (2) @(posedge clk);
		#1 chk(32'(irq_id), 32'h0C);
		chk(32'(lvl), 32'h2);
		wr_reg(8'hF8, 8'h00);
		wr_reg(8'hB8, 8'h02);
		repeat (2) @(posedge clk);
		#1 chk(32'(irq_id), 32'h05);
		chk(32'(lvl), 32'h1);
	endtask : t_prio

	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		end_of_test();
	end

	initial begin
		nrst   = 1'h0;
		wr     = 1'h0;
		rd     = 1'h0;
		addr   = 8'h00;
		wdata  = 8'h00;
		pin    = 8'h00;
		src    = 32'h0;
		svc_en = 1'h0;
		dly    = 4'h2;
		repeat (12) @(posedge clk);
		nrst <= 1'h1;
		t_regs();
		t_trig(3'h0, 1'h0, 1'h1, 1'h1, 1'h1);
		t_trig(3'h2, 1'h1, 1'h0, 1'h1, 1'h1);
		t_trig(3'h0, 1'h0, 1'h1, 1'h0, 1'h0);
		t_trig(3'h1, 1'h0, 1'h1, 1'h1, 1'h1);
		t_trig(3'h1, 1'h1, 1'h0, 1'h1, 1'h0);
		t_trig(3'h3, 1'h1, 1'h0, 1'h1, 1'h1);
		t_trig(3'h3, 1'h0, 1'h1, 1'h1, 1'h0);
		t_trig(3'h4, 1'h1, 1'h0, 1'h1, 1'h1);
		t_trig(3'h4, 1'h1, 1'h1, 1'h1, 1'h0);
		t_serve();
		t_prio();
		end_of_test();
	end
endmodule : irq_enable_priority_extint_tb
